/* File: inc/dac_link_pkg.sv */
package dac_link_pkg;
  localparam int WORD_BITS = 16;
  localparam logic [15:0] MIDCODE = 16'h0000;
  localparam logic [15:0] CODE_POS_FULL = 16'h7fff;
  localparam logic [15:0] CODE_NEG_FULL = 16'h8000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCK_PERIOD_MIN_NS = 20;
  localparam int SCK_HALF_MIN_NS = 10;
  localparam int LEAD_MIN_NS = 20;
  localparam int DESELECT_GAP_MIN_NS = 20;
  localparam int WAIT_MIN_NS = 100;
  localparam int POWER_UP_MIN_US = 100;
  localparam int HALF_CYCLES = (SCK_HALF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEAD_CYCLES = (LEAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYCLES = (DESELECT_GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_CYCLES = (WAIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWER_UP_CYCLES = (POWER_UP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* File: inc/dac_link_if.sv */
`timescale 1ns/1ps
interface dac_link_if;
  logic select_n;
  logic bit_clk;
  logic serial_data_input;
  logic force_midscale_n;
  modport host (output select_n, output bit_clk, output serial_data_input,
                output force_midscale_n);
  modport device (input select_n, input bit_clk, input serial_data_input,
                  input force_midscale_n);
endinterface

/* File: core/dac_load_port.sv */
`timescale 1ns/1ps
// Operation
// RULE1 - Ignore data input while select high
// RULE2 - Ignore bit clock edges while select high
// RULE3 - Select active low; bits only while low
// RULE4 - Clear low at 16th: load midcode
// RULE5 - Clear high at 16th: load shift register
// RULE6 - Clear active low, forces midscale
// RULE7 - Host bit clock half periods >= 10 ns
// RULE8 - Host waits 20 ns before first edge
// RULE9 - Host keeps select high >= 20 ns
// RULE10 - Host waits 100 ns after 16th fall
// RULE11 - Host waits 100 us after power up
// RULE12 - Shift on rising edge, MSB first
// RULE13 - Ignore clocks after update; discard partials
// RULE14 - Code is twos complement
// RULE15 - Clear does not disturb shifting
// RULE16 - Host sends exactly sixteen clocks per word
module dac_load_port (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Link
  dac_link_if.device       link,
  // Latched code
  output logic [15:0]      dac_code,
  output logic             code_valid,
  input  wire logic        code_ready
);
  typedef struct packed {
    logic [1:0]  sel_sync;
    logic [1:0]  clk_sync;
    logic [1:0]  dat_sync;
    logic [1:0]  clr_sync;
    logic        clk_prev;
    logic [15:0] shift;
    logic [4:0]  count;
    logic        done;
    logic [15:0] latch;
    logic [1:0]  buf_cnt;
    logic [15:0] buf0;
    logic [15:0] buf1;
  } state_t;
  state_t s_reg, s_next;
  logic sel_n, clk_s, rise, fall, push, pop;

  assign sel_n = s_reg.sel_sync[1];
  assign clk_s = s_reg.clk_sync[1];
  assign rise = clk_s && !s_reg.clk_prev && !sel_n && !s_reg.done; // see RULE2, see RULE13
  assign fall = !clk_s && s_reg.clk_prev && !sel_n && !s_reg.done && (s_reg.count == 5'd16);
  assign pop = code_valid && code_ready;
  assign push = fall;
  assign code_valid = (s_reg.buf_cnt != 2'd0);
  assign dac_code = s_reg.latch;

  always_comb begin
    s_next = s_reg;
    s_next.sel_sync = {s_reg.sel_sync[0], link.select_n};
    s_next.clk_sync = {s_reg.clk_sync[0], link.bit_clk};
    s_next.dat_sync = {s_reg.dat_sync[0], link.serial_data_input};
    s_next.clr_sync = {s_reg.clr_sync[0], link.force_midscale_n};
    s_next.clk_prev = clk_s;
    if (sel_n) begin // see RULE1, see RULE3
      s_next.count = 5'd0;
      s_next.done = 1'b0;
    end else if (rise && s_reg.count < 5'd16) begin
      s_next.shift = {s_reg.shift[14:0], s_reg.dat_sync[1]}; // see RULE12, see RULE15
      s_next.count = s_reg.count + 5'd1;
    end
    if (fall) begin
      s_next.done = 1'b1; // see RULE13
      if (!s_reg.clr_sync[1]) s_next.latch = dac_link_pkg::MIDCODE; // see RULE4, see RULE6
      else s_next.latch = s_reg.shift; // see RULE5, see RULE14
    end
    // Two-entry word buffer toward the consumer; oldest at buf0
    if (pop) begin
      s_next.buf0 = s_reg.buf1;
    end
    if (push && s_reg.buf_cnt != 2'd2) begin
      if (pop) begin
        if (s_reg.buf_cnt == 2'd1) s_next.buf0 = s_next.latch;
        else s_next.buf1 = s_next.latch;
      end else if (s_reg.buf_cnt == 2'd0) s_next.buf0 = s_next.latch;
      else s_next.buf1 = s_next.latch;
    end
    s_next.buf_cnt = s_reg.buf_cnt + ((push && s_reg.buf_cnt != 2'd2) ? 2'd1 : 2'd0)
                     - (pop ? 2'd1 : 2'd0);
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_reg <= '0;
      s_reg.sel_sync <= 2'h3;
      s_reg.clr_sync <= 2'h3;
      s_reg.latch <= dac_link_pkg::MIDCODE;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

/* File: core/dac_load_host.sv */
`timescale 1ns/1ps
module dac_load_host #(
  parameter int POWER_UP_CYCLES = dac_link_pkg::POWER_UP_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Word request
  input  wire logic [15:0] word_data,
  input  wire logic        word_valid,
  output logic             word_ready,
  input  wire logic        clear_req_n,
  // Link
  dac_link_if.host         link,
  output logic             busy
);
  typedef enum logic [2:0] {
    ST_POWER = 3'b000, ST_IDLE = 3'b001, ST_LEAD = 3'b010,
    ST_LOW = 3'b011, ST_HIGH = 3'b100, ST_WAIT = 3'b101
  } st_t;
  typedef struct packed {
    st_t         st;
    logic [22:0] timer;
    logic [15:0] shift;
    logic [4:0]  bits;
    logic        sel_n;
    logic        sck;
    logic        sdo;
    logic        clr_n;
  } state_t;
  state_t s_reg, s_next;

  assign word_ready = (s_reg.st == ST_IDLE);
  assign busy = !word_ready;
  assign link.select_n = s_reg.sel_n;
  assign link.bit_clk = s_reg.sck;
  assign link.serial_data_input = s_reg.sdo;
  assign link.force_midscale_n = s_reg.clr_n;

  always_comb begin
    s_next = s_reg;
    if (s_reg.timer != 23'd0) s_next.timer = s_reg.timer - 23'd1;
    case (s_reg.st)
      ST_POWER: if (s_reg.timer == 23'd0) s_next.st = ST_IDLE; // see RULE11
      ST_IDLE: if (word_valid) begin
        s_next.shift = word_data;
        s_next.clr_n = clear_req_n;
        s_next.sel_n = 1'b0; // see RULE3
        s_next.sdo = word_data[15];
        s_next.bits = 5'd0;
        s_next.timer = 23'(dac_link_pkg::LEAD_CYCLES);
        s_next.st = ST_LEAD;
      end
      ST_LEAD: if (s_reg.timer == 23'd0) begin // see RULE8
        s_next.sck = 1'b1;
        s_next.bits = s_reg.bits + 5'd1;
        s_next.timer = 23'(dac_link_pkg::HALF_CYCLES);
        s_next.st = ST_HIGH;
      end
      ST_HIGH: if (s_reg.timer == 23'd0) begin // see RULE7
        s_next.sck = 1'b0;
        s_next.shift = {s_reg.shift[14:0], 1'b0};
        s_next.sdo = s_reg.shift[14];
        s_next.timer = 23'(dac_link_pkg::HALF_CYCLES);
        if (s_reg.bits == 5'd16) begin // see RULE16
          s_next.timer = 23'(dac_link_pkg::WAIT_CYCLES);
          s_next.st = ST_WAIT;
        end else s_next.st = ST_LOW;
      end
      ST_LOW: if (s_reg.timer == 23'd0) begin
        s_next.sck = 1'b1;
        s_next.bits = s_reg.bits + 5'd1;
        s_next.timer = 23'(dac_link_pkg::HALF_CYCLES);
        s_next.st = ST_HIGH;
      end
      ST_WAIT: begin
        s_next.sel_n = 1'b1;
        if (s_reg.timer == 23'd0) s_next.st = ST_IDLE; // see RULE9, see RULE10
      end
      default: s_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_reg <= '0;
      s_reg.st <= ST_POWER;
      s_reg.sel_n <= 1'b1;
      s_reg.clr_n <= 1'b1;
      s_reg.timer <= 23'(POWER_UP_CYCLES);
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

/* File: bench/dac_link_monitor.sv */
`timescale 1ns/1ps
module dac_link_monitor #(
  parameter int POWER_UP_CYCLES = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Link
  input wire logic select_n,
  input wire logic bit_clk,
  input wire logic serial_data_input,
  input wire logic force_midscale_n
);
  int cnt;
  int up;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence lead_low; !bit_clk [*2]; endsequence
  sequence no_refall; !$fell(select_n) [*5]; endsequence
  // Rising bit clocks in this frame, and cycles since reset
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cnt <= 0;
      up  <= 0;
    end else begin
      cnt <= select_n ? 0 : cnt + int'($rose(bit_clk));
      up  <= (up < POWER_UP_CYCLES) ? up + 1 : up;
    end
  end
  a_power_up_wait: assert property (up < POWER_UP_CYCLES - 1 |-> select_n)
    else $error("select early");
  a_lead_delay: assert property ($fell(select_n) |-> lead_low)
    else $error("lead short");
  a_idle_clock: assert property (select_n |-> !bit_clk)
    else $error("clock idle");
  a_wait_gap: assert property ($fell(bit_clk) && cnt == 16 |-> no_refall)
    else $error("wait short");
  a_sixteen_clocks: assert property ($rose(select_n) |-> cnt == 16)
    else $error("count");
  a_no_extra: assert property (cnt == 16 |-> !$rose(bit_clk))
    else $error("extra clock");
  a_high_phase: assert property ($rose(bit_clk) |=> ##[0:1] $fell(bit_clk))
    else $error("high phase");
  a_low_phase: assert property ($fell(bit_clk) && cnt < 16 |=> ##[0:1] $rose(bit_clk))
    else $error("low phase");
  a_data_setup: assert property ($rose(bit_clk) |-> $stable(serial_data_input))
    else $error("setup");
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        core_clk, reset_n, word_valid, clear_req_n, code_ready, word_ready, code_valid;
  logic [15:0] word_data, dac_code, dac_code2;
  logic [15:0] vals [4] = '{dac_link_pkg::CODE_POS_FULL, dac_link_pkg::CODE_NEG_FULL,
                            dac_link_pkg::MIDCODE, 16'ha5c3};
  int          bad_count, n_checks, k, n;
  dac_link_if link();
  dac_link_if link2();
  dac_load_host #(.POWER_UP_CYCLES(10)) dac_load_host_i (.core_clk, .reset_n, .word_data,
    .word_valid, .word_ready, .clear_req_n, .link(link), .busy());
  dac_load_port dac_load_port_i (.core_clk, .reset_n, .link(link), .dac_code, .code_valid,
    .code_ready);
  dac_load_port dac_load_port_i2 (.core_clk, .reset_n, .link(link2), .dac_code(dac_code2),
    .code_valid(), .code_ready(1'b1));
  dac_link_monitor #(.POWER_UP_CYCLES(10)) dac_link_monitor_i (.core_clk, .reset_n,
    .select_n(link.select_n), .bit_clk(link.bit_clk),
    .serial_data_input(link.serial_data_input), .force_midscale_n(link.force_midscale_n));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic limit;
    if (k == 999) begin
      bad_count++;
      end_sim();
    end
  endtask
  task automatic send(input logic [15:0] w, input logic c);
    @(posedge core_clk);
    word_data   <= w;
    clear_req_n <= c;
    word_valid  <= 1'b1;
    for (k = 0; k < 999 && word_ready !== 1'b1; k++) @(negedge core_clk);
    limit();
    @(posedge core_clk);
    word_valid <= 1'b0;
  endtask
  task automatic pop(input logic [15:0] exp);
    for (k = 0; k < 999 && code_valid !== 1'b1; k++) @(negedge core_clk);
    limit();
    chk("code", exp, dac_code);
    @(posedge core_clk);
    code_ready <= 1'b1;
    @(posedge core_clk);
    code_ready <= 1'b0;
  endtask
  // Far-end frame at 160 ns bit clock; data moves on the falling edge
  task automatic frame(input logic [15:0] w, input int bits, input logic sel_n);
    int i;
    @(posedge core_clk);
    link2.select_n <= sel_n;
    for (i = 0; i < bits; i++) begin
      link2.serial_data_input <= (i < 16) ? w[15-i] : !w[i-16];
      repeat (4) @(posedge core_clk);
      link2.bit_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
      link2.bit_clk <= 1'b0;
    end
    repeat (8) @(posedge core_clk);
    link2.select_n <= 1'b1;
    link2.serial_data_input <= !link2.serial_data_input;
    repeat (8) @(posedge core_clk);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    reset_n = 1'b0;
    word_valid = 1'b0;
    word_data = 16'h0000;
    clear_req_n = 1'b1;
    code_ready = 1'b0;
    link2.select_n = 1'b1;
    link2.bit_clk = 1'b0;
    link2.serial_data_input = 1'b0;
    link2.force_midscale_n = 1'b1;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (vals[i]) begin
      send(vals[i], 1'b1);
      pop(vals[i]);
    end
    send(16'h1234, 1'b0);
    pop(16'h0000);
    send(16'h5678, 1'b1);
    pop(16'h5678);
    send(16'h1111, 1'b1);
    send(16'h2222, 1'b1);
    send(16'h3333, 1'b1);
    for (k = 0; k < 999 && dac_code !== 16'h3333; k++) @(negedge core_clk);
    limit();
    @(posedge core_clk);
    code_ready <= 1'b1;
    n = 0;
    repeat (4) begin
      @(negedge core_clk);
      n += int'(code_valid === 1'b1);
    end
    chk("pops", 16'h0002, 16'(n));
    @(posedge core_clk);
    code_ready <= 1'b0;
    frame(16'h1357, 16, 1'b0);
    chk("far", 16'h1357, dac_code2);
    frame(16'h0f0f, 16, 1'b1);
    chk("far", 16'h1357, dac_code2);
    frame(16'hffff, 8, 1'b0);
    chk("far", 16'h1357, dac_code2);
    frame(16'h2468, 24, 1'b0);
    chk("far", 16'h2468, dac_code2);
    link2.force_midscale_n <= 1'b0;
    frame(16'h4c4c, 16, 1'b0);
    chk("far", dac_link_pkg::MIDCODE, dac_code2);
    link2.force_midscale_n <= 1'b1;
    frame(16'h4c4c, 16, 1'b0);
    chk("far", 16'h4c4c, dac_code2);
    end_sim();
  end
endmodule
